/* File: wbc_regs.vh */
/*
  constants for the watchdog and bus control register bank.
  assumes inclusion by bare name from the design files.
*/
`ifndef WBC_REGS_VH
`define WBC_REGS_VH

`define WBC_ADDR_WD        7'h03
`define WBC_ADDR_BUS1      7'h04
`define WBC_ADDR_BUS2      7'h05

`define WBC_WD_POR         8'h14
`define WBC_BUS1_POR       8'h20
`define WBC_BUS2_POR       8'h00

`define WBC_WD_RESTART_PER 3'h4
`define WBC_WD_KEEP_MASK   8'hB0
`define WBC_BUS1_KEEP_MASK 8'hE0
`define WBC_BUS2_KEEP_MASK 8'h20

`define WBC_WD_RD_MASK     8'hF7
`define WBC_BUS1_RD_MASK   8'hFB
`define WBC_BUS2_RD_MASK   8'h23

`define WBC_BUS1_FS_FIXED  8'h09
`define WBC_BUS2_FS        8'h01
`define WBC_EXTWAKE_FS     8'h07
`define WBC_EXTWAKE_FS_M   8'h47

`define WBC_BIT_STOP_OFF   6
`define WBC_BIT_WINDOW     5
`define WBC_BIT_BUS_WAKE   4
`define WBC_BIT_LIN_FLASH  7
`define WBC_BIT_LIN_LOW_SLOPE    6
`define WBC_BIT_LIN_TXDTO  5
`define WBC_BIT_PEAK       5

`define WBC_MODE_INIT      2'h0
`define WBC_MODE_NORMAL    2'h1
`define WBC_MODE_STOP      2'h2

`define WBC_FRAME_BITS     5'h10
`define WBC_ADDR_BITS      5'h08

`define WBC_PER_10MS       11'h00A
`define WBC_PER_20MS       11'h014
`define WBC_PER_50MS       11'h032
`define WBC_PER_100MS      11'h064
`define WBC_PER_200MS      11'h0C8
`define WBC_PER_500MS      11'h1F4
`define WBC_PER_1000MS     11'h3E8

`endif

/* File: wbc_period_decode.v */
/*
  decodes the 3-bit watchdog period code into milliseconds.
  assumes a purely combinational use by the register bank.
*/
`timescale 1ns/1ns
`include "wbc_regs.vh"

module wbc_period_decode
(
  input  wire [2:0]  code,
  output reg  [10:0] period_ms,
  output reg         reserved
);

  always @*
  begin
    reserved = 1'b0;
    case (code)
      3'h0:    period_ms = `WBC_PER_10MS;
      3'h1:    period_ms = `WBC_PER_20MS;
      3'h2:    period_ms = `WBC_PER_50MS;
      3'h3:    period_ms = `WBC_PER_100MS;
      3'h4:    period_ms = `WBC_PER_200MS;
      3'h5:    period_ms = `WBC_PER_500MS;
      3'h6:    period_ms = `WBC_PER_1000MS;
      default:
      begin
        // code 111 holds no period; use the longest legal one (1000 ms)
        period_ms = `WBC_PER_1000MS;
        reserved  = 1'b1;
      end
    endcase
  end

endmodule

/* File: wbc_spi_slave.v */
/*
  serial slave: 16-bit frames, lsb first, address byte then data byte.
  assumes sck idles low, data sampled on rising and changed on falling sck.
*/
`timescale 1ns/1ns
`include "wbc_regs.vh"

module wbc_spi_slave
(
  input  wire       clk,
  input  wire       rst_n,
  input  wire       sck,
  input  wire       chip_select_n,
  input  wire       mosi,
  output reg        miso,
  output wire       miso_oe,
  output reg        addr_valid,
  output reg  [6:0] addr,
  output reg        wr_flag,
  input  wire [7:0] rd_data,
  output reg        frame_done,
  output reg        frame_ok,
  output reg  [7:0] wr_data
);

  reg [2:0]  sck_s;
  reg [2:0]  cs_s;
  reg [1:0]  mosi_s;
  reg [4:0]  cnt;
  reg [15:0] rx;
  reg [7:0]  tx;
  reg        load;

  wire sck_rise = sck_s[1] & ~sck_s[2];
  wire sck_fall = ~sck_s[1] & sck_s[2];
  wire cs_act   = ~cs_s[1];
  wire cs_rise  = cs_s[1] & ~cs_s[2];

  assign miso_oe = cs_act;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_s      <= 3'h0;
      cs_s       <= 3'h7;
      mosi_s     <= 2'h0;
      cnt        <= 5'h00;
      rx         <= 16'h0000;
      tx         <= 8'h00;
      load       <= 1'b0;
      miso       <= 1'b0;
      addr_valid <= 1'b0;
      addr       <= 7'h00;
      wr_flag    <= 1'b0;
      frame_done <= 1'b0;
      frame_ok   <= 1'b0;
      wr_data    <= 8'h00;
    end
    else
    begin
      sck_s      <= {sck_s[1:0], sck};
      cs_s       <= {cs_s[1:0], chip_select_n};
      mosi_s     <= {mosi_s[0], mosi};
      addr_valid <= 1'b0;
      frame_done <= 1'b0;
      load       <= addr_valid;
      if (!cs_act)
      begin
        cnt  <= 5'h00;
        miso <= 1'b0;
        tx   <= 8'h00;
      end
      else if (sck_rise && cnt != `WBC_FRAME_BITS)
      begin
        rx  <= {mosi_s[1], rx[15:1]};
        cnt <= cnt + 5'h01;
        if (cnt == `WBC_ADDR_BITS - 5'h01)
        begin
          addr       <= rx[15:9];
          wr_flag    <= mosi_s[1];
          addr_valid <= 1'b1;
        end
      end
      // old contents captured before any write of this frame
      if (load)
        tx <= rd_data;
      else if (cs_act && sck_fall && cnt >= `WBC_ADDR_BITS && cnt != `WBC_FRAME_BITS)
      begin
        miso <= tx[0];
        tx   <= {1'b0, tx[7:1]};
      end
      if (cs_rise)
      begin
        frame_done <= 1'b1;
        frame_ok   <= (cnt == `WBC_FRAME_BITS);
        wr_data    <= rx[15:8];
      end
    end
  end

endmodule

/* File: wbc_regs.v */
/*
  watchdog control and bus transceiver control registers behind a serial port.
  assumes mode, restart, soft reset and fail-safe inputs come from clk-domain logic,
  and serial pins come asynchronously and are synchronised here.
*/
`timescale 1ns/1ns
`include "wbc_regs.vh"

module wbc_regs
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        sck,
  input  wire        chip_select_n,
  input  wire        mosi,
  output wire        miso,
  output wire        miso_oe,
  input  wire [1:0]  sbc_mode,
  input  wire        soft_reset,
  input  wire        restart,
  input  wire        failsafe_entry,
  input  wire [1:0]  restart_can_mode,
  input  wire [1:0]  restart_first_lin_mode,
  input  wire [1:0]  restart_second_lin_mode,
  input  wire        hw_stop_off_we,
  input  wire        hw_stop_off_val,
  input  wire        hw_bus_wake_we,
  input  wire        hw_bus_wake_val,
  input  wire        hw_period_we,
  input  wire [2:0]  hw_period_val,
  input  wire        hw_can_we,
  input  wire [1:0]  hw_can_val,
  input  wire        hw_first_lin_we,
  input  wire [1:0]  hw_first_lin_val,
  input  wire        hw_second_lin_we,
  input  wire [1:0]  hw_second_lin_val,
  output wire        stop_watchdog_off_bit0,
  output wire        window_type_select,
  output wire        watchdog_start_on_bus_wake,
  output wire [2:0]  watchdog_period,
  output reg  [10:0] watchdog_period_ms,
  output reg         watchdog_period_reserved,
  output reg         watchdog_parity_ok,
  output wire        lin_flash,
  output wire        lin_low_slope,
  output wire        lin_transmit_timeout_en,
  output wire [1:0]  first_lin_mode,
  output wire [1:0]  can_mode,
  output wire [1:0]  second_lin_mode,
  output wire        peak_current_threshold,
  output reg         external_wake_force,
  output wire [7:0]  external_wake_value,
  output wire [7:0]  external_wake_mask
);

  reg  [7:0]  watchdog_control;
  reg  [7:0]  bus_transceiver_control;
  reg  [7:0]  peak_and_second_lin_control;
  reg  [7:0]  next_wd;
  reg  [7:0]  next_bus1;
  reg  [7:0]  next_bus2;
  reg  [7:0]  rd_data;
  wire        addr_valid;
  wire [6:0]  addr;
  wire        wr_flag;
  wire        frame_done;
  wire        frame_ok;
  wire [7:0]  wr_data;
  wire [10:0] dec_ms;
  wire        dec_res;
  wire        do_write;

  function [7:0] keep_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] keep;
    begin
      keep_merge = (old_v & keep) | (new_v & ~keep);
    end
  endfunction

  wbc_spi_slave u_spi
  (
    .clk           (clk),
    .rst_n         (rst_n),
    .sck           (sck),
    .chip_select_n (chip_select_n),
    .mosi          (mosi),
    .miso          (miso),
    .miso_oe       (miso_oe),
    .addr_valid    (addr_valid),
    .addr          (addr),
    .wr_flag       (wr_flag),
    .rd_data       (rd_data),
    .frame_done    (frame_done),
    .frame_ok      (frame_ok),
    .wr_data       (wr_data)
  );

  wbc_period_decode u_dec
  (
    .code      (watchdog_control[2:0]),
    .period_ms (dec_ms),
    .reserved  (dec_res)
  );

  // read view masks out reserved positions
  always @*
  begin
    case (addr)
      `WBC_ADDR_WD:   rd_data = watchdog_control & `WBC_WD_RD_MASK;
      `WBC_ADDR_BUS1: rd_data = bus_transceiver_control & `WBC_BUS1_RD_MASK;
      `WBC_ADDR_BUS2: rd_data = peak_and_second_lin_control & `WBC_BUS2_RD_MASK;
      default:        rd_data = 8'h00;
    endcase
  end

  // writes commit only on a complete frame at chip select release
  assign do_write = frame_done & frame_ok & wr_flag;

  always @*
  begin
    next_wd   = watchdog_control;
    next_bus1 = bus_transceiver_control;
    next_bus2 = peak_and_second_lin_control;
    if (do_write)
    begin
      case (addr)
        `WBC_ADDR_WD:   next_wd   = wr_data & `WBC_WD_RD_MASK;
        `WBC_ADDR_BUS1: next_bus1 = wr_data & `WBC_BUS1_RD_MASK;
        `WBC_ADDR_BUS2:
        begin
          next_bus2 = wr_data & `WBC_BUS2_RD_MASK;
          // stop mode keeps the old peak bit, no failure flagged
          if (sbc_mode == `WBC_MODE_STOP)
            next_bus2[`WBC_BIT_PEAK] = peak_and_second_lin_control[`WBC_BIT_PEAK];
        end
        default:
        begin
          next_wd = watchdog_control;
        end
      endcase
    end
    // hardware updates win over a same-cycle host write
    if (hw_stop_off_we)
      next_wd[`WBC_BIT_STOP_OFF] = hw_stop_off_val;
    if (hw_bus_wake_we)
      next_wd[`WBC_BIT_BUS_WAKE] = hw_bus_wake_val;
    if (hw_period_we)
      next_wd[2:0] = hw_period_val;
    if (hw_can_we)
      next_bus1[1:0] = hw_can_val;
    if (hw_first_lin_we)
      next_bus1[4:3] = hw_first_lin_val;
    if (hw_second_lin_we)
      next_bus2[1:0] = hw_second_lin_val;
    if (restart)
    begin
      next_wd   = keep_merge(watchdog_control,
                             {5'h00, `WBC_WD_RESTART_PER}, `WBC_WD_KEEP_MASK);
      next_bus1 = keep_merge(bus_transceiver_control,
                             {3'h0, restart_first_lin_mode, 1'b0, restart_can_mode},
                             `WBC_BUS1_KEEP_MASK);
      next_bus2 = keep_merge(peak_and_second_lin_control,
                             {6'h00, restart_second_lin_mode},
                             `WBC_BUS2_KEEP_MASK);
    end
    if (failsafe_entry)
    begin
      next_bus1 = keep_merge(bus_transceiver_control,
                             `WBC_BUS1_FS_FIXED, `WBC_BUS1_KEEP_MASK);
      next_bus2 = `WBC_BUS2_FS;
    end
    if (soft_reset)
    begin
      next_wd   = `WBC_WD_POR;
      next_bus1 = `WBC_BUS1_POR;
      next_bus2 = `WBC_BUS2_POR;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      watchdog_control            <= `WBC_WD_POR;
      bus_transceiver_control     <= `WBC_BUS1_POR;
      peak_and_second_lin_control <= `WBC_BUS2_POR;
      external_wake_force         <= 1'b0;
      watchdog_period_ms          <= `WBC_PER_200MS;
      watchdog_period_reserved    <= 1'b0;
      watchdog_parity_ok          <= 1'b0;
    end
    else
    begin
      watchdog_control            <= next_wd;
      bus_transceiver_control     <= next_bus1;
      peak_and_second_lin_control <= next_bus2;
      external_wake_force         <= failsafe_entry & ~soft_reset;
      watchdog_period_ms          <= dec_ms;
      watchdog_period_reserved    <= dec_res;
      // host is expected to send even parity; flag shows whether the stored value has even parity
      watchdog_parity_ok          <= ~^watchdog_control;
    end
  end

  assign external_wake_value        = `WBC_EXTWAKE_FS;
  assign external_wake_mask         = `WBC_EXTWAKE_FS_M;
  assign stop_watchdog_off_bit0     = watchdog_control[`WBC_BIT_STOP_OFF];
  assign window_type_select         = watchdog_control[`WBC_BIT_WINDOW];
  assign watchdog_start_on_bus_wake = watchdog_control[`WBC_BIT_BUS_WAKE];
  assign watchdog_period            = watchdog_control[2:0];
  assign lin_flash                  = bus_transceiver_control[`WBC_BIT_LIN_FLASH];
  assign lin_low_slope              = bus_transceiver_control[`WBC_BIT_LIN_LOW_SLOPE];
  assign lin_transmit_timeout_en    = bus_transceiver_control[`WBC_BIT_LIN_TXDTO];
  assign first_lin_mode             = bus_transceiver_control[4:3];
  assign can_mode                   = bus_transceiver_control[1:0];
  assign second_lin_mode            = peak_and_second_lin_control[1:0];
  assign peak_current_threshold     = peak_and_second_lin_control[`WBC_BIT_PEAK];

endmodule

/* File: wbc_regs_assertions.sv */
/*
  property checker for the watchdog and bus control register bank.
  assumes one clk domain and a bind onto wbc_regs ports.
*/
`timescale 1ns/1ns
`include "wbc_regs.vh"
module wbc_regs_chk
(
  input wire        clk,
  input wire        rst_n,
  input wire        chip_select_n,
  input wire [1:0]  sbc_mode,
  input wire        soft_reset,
  input wire        restart,
  input wire        failsafe_entry,
  input wire        stop_watchdog_off_bit0,
  input wire        window_type_select,
  input wire [2:0]  watchdog_period,
  input wire [10:0] watchdog_period_ms,
  input wire        watchdog_period_reserved,
  input wire        lin_low_slope,
  input wire [1:0]  first_lin_mode,
  input wire        peak_current_threshold,
  input wire        external_wake_force
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // reserved code holds the longest period
  function [10:0] ms_of(input [2:0] c);
    case (c)
      3'h0: ms_of = 11'h00A;
      3'h1: ms_of = 11'h014;
      3'h2: ms_of = 11'h032;
      3'h3: ms_of = 11'h064;
      3'h4: ms_of = 11'h0C8;
      3'h5: ms_of = 11'h1F4;
      default: ms_of = 11'h3E8;
    endcase
  endfunction

  sequence fs_hit;
    failsafe_entry && !soft_reset;
  endsequence
  sequence rs_hit;
    restart && !soft_reset && !failsafe_entry;
  endsequence

  a_period_decode: assert property (1'b1 |=> watchdog_period_ms == ms_of($past(watchdog_period)))
    else $error("period decode wrong");
  a_period_reserved: assert property (1'b1 |=> watchdog_period_reserved == ($past(watchdog_period) == 3'h7))
    else $error("reserved period flag wrong");
  a_failsafe_modes: assert property (fs_hit |=> first_lin_mode == 2'h1 && !peak_current_threshold)
    else $error("fail-safe values wrong");
  a_wake_force_pulse: assert property (fs_hit |=> external_wake_force ##1 !external_wake_force)
    else $error("external wake force pulse wrong");
  a_soft_defaults: assert property (soft_reset |=> !stop_watchdog_off_bit0 && !window_type_select
    && watchdog_period == 3'h4 && !lin_low_slope && first_lin_mode == 2'h0)
    else $error("soft reset values wrong");
  a_restart_values: assert property (rs_hit |=> !stop_watchdog_off_bit0 && watchdog_period == 3'h4
    && $stable(window_type_select) && $stable(peak_current_threshold))
    else $error("restart values wrong");
  a_peak_in_stop: assert property (sbc_mode == `WBC_MODE_STOP && !soft_reset && !failsafe_entry
    |=> $stable(peak_current_threshold))
    else $error("peak bit changed in stop");
  a_options_at_cs: assert property ($changed(lin_low_slope) && !$past(soft_reset)
    |-> chip_select_n && $past(chip_select_n, 2))
    else $error("lin option changed inside frame");
endmodule

bind wbc_regs wbc_regs_chk u_chk (.clk, .rst_n, .chip_select_n, .sbc_mode, .soft_reset, .restart,
  .failsafe_entry, .stop_watchdog_off_bit0, .window_type_select, .watchdog_period,
  .watchdog_period_ms, .watchdog_period_reserved, .lin_low_slope, .first_lin_mode,
  .peak_current_threshold, .external_wake_force);

/* File: wbc_host.sv */
/*
  host model: serial master sending 16-bit lsb-first frames.
  assumes sck phases of 6 clk, well above the bank's synchroniser needs.
*/
`timescale 1ns/1ns
module wbc_host
(
  input  wire clk,
  input  wire miso,
  output reg  sck,
  output reg  chip_select_n,
  output reg  mosi
);
  initial
  begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end

  function [7:0] with_sum(input [6:0] v);
    with_sum = {^v, v};
  endfunction

  task frame(input [6:0] a, input w, input [7:0] d, output [7:0] q);
    reg [15:0] f;
    integer    i;
    begin
      f = {d, w, a};
      q = 8'h00;
      @(posedge clk);
      chip_select_n <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
      begin
        mosi <= f[i];
        repeat (6) @(posedge clk);
        if (i > 7)
          q[i - 8] = miso;
        sck <= 1'b1;
        repeat (6) @(posedge clk);
        sck <= 1'b0;
      end
      repeat (6) @(posedge clk);
      chip_select_n <= 1'b1;
      // mosi flipped between frames; it idles at the inverse of the last data bit
      mosi <= ~mosi;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule

/* File: tb.sv */
/*
  self-checking bench for wbc_regs driven through the host model.
  assumes 20 MHz clk and the wbc_host serial master.
*/
`timescale 1ns/1ns
`include "wbc_regs.vh"
module tb;
  reg        clk, rst_n, soft_reset, restart, failsafe_entry, hw_stop_off_we, hw_stop_off_val;
  reg        hw_bus_wake_we, hw_bus_wake_val, hw_period_we, hw_can_we, hw_first_lin_we;
  reg        hw_second_lin_we;
  reg  [1:0] sbc_mode, restart_can_mode, restart_first_lin_mode, restart_second_lin_mode;
  reg  [1:0] hw_can_val, hw_first_lin_val, hw_second_lin_val;
  reg  [2:0] hw_period_val;
  reg  [7:0] q;
  wire       sck, chip_select_n, mosi, miso, miso_oe, stop_watchdog_off_bit0;
  wire       window_type_select, watchdog_start_on_bus_wake, watchdog_period_reserved;
  wire       watchdog_parity_ok, lin_flash, lin_low_slope, lin_transmit_timeout_en;
  wire       peak_current_threshold, external_wake_force;
  wire [1:0] first_lin_mode, can_mode, second_lin_mode;
  wire [2:0] watchdog_period;
  wire [10:0] watchdog_period_ms;
  wire [7:0] external_wake_value, external_wake_mask;
  integer    err_count = 0;
  integer    n_compared = 0;
  integer    cyc = 0;

  wbc_regs DUT (.clk, .rst_n, .sck, .chip_select_n, .mosi, .miso, .miso_oe, .sbc_mode,
    .soft_reset, .restart, .failsafe_entry, .restart_can_mode, .restart_first_lin_mode,
    .restart_second_lin_mode, .hw_stop_off_we, .hw_stop_off_val, .hw_bus_wake_we,
    .hw_bus_wake_val, .hw_period_we, .hw_period_val, .hw_can_we, .hw_can_val,
    .hw_first_lin_we, .hw_first_lin_val, .hw_second_lin_we, .hw_second_lin_val,
    .stop_watchdog_off_bit0, .window_type_select, .watchdog_start_on_bus_wake,
    .watchdog_period, .watchdog_period_ms, .watchdog_period_reserved, .watchdog_parity_ok,
    .lin_flash, .lin_low_slope, .lin_transmit_timeout_en, .first_lin_mode, .can_mode,
    .second_lin_mode, .peak_current_threshold, .external_wake_force, .external_wake_value,
    .external_wake_mask);
  wbc_host host (.clk, .miso, .sck, .chip_select_n, .mosi);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc = cyc + 1;
    // about 40 frames of 210 clk each fit well below this
    if (cyc == 30000)
    begin
      err_count = err_count + 1;
      final_report;
    end
  end

  task chk(input [8*8:1] nm, input [16:0] e, input [16:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task final_report;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task wr(input [6:0] a, input [7:0] d);
    host.frame(a, 1'b1, d, q);
  endtask

  task rd(input [6:0] a);
    host.frame(a, 1'b0, 8'h00, q);
  endtask

  task t_por;
    begin
      chk("miso_oe", 1'b0, miso_oe);
      rd(`WBC_ADDR_WD);
      chk("wd", 8'h14, q);
      rd(`WBC_ADDR_BUS1);
      chk("bus1", 8'h20, q);
      rd(`WBC_ADDR_BUS2);
      chk("bus2", 8'h00, q);
      $display("test defaults done");
    end
  endtask

  task t_wd;
    integer   c;
    reg [7:0] v, p;
    reg [10:0] ms [0:6];
    begin
      ms = '{11'h00A, 11'h014, 11'h032, 11'h064, 11'h0C8, 11'h1F4, 11'h3E8};
      p = 8'h14;
      for (c = 0; c < 7; c = c + 1)
      begin
        v = host.with_sum({c[0], c[1], ~c[0], 1'b0, c[2:0]});
        wr(`WBC_ADDR_WD, v);
        chk("wd_old", p, q);
        chk("ms", ms[c], watchdog_period_ms);
        chk("wd_bits", {c[0], c[1], ~c[0]}, {stop_watchdog_off_bit0, window_type_select,
          watchdog_start_on_bus_wake});
        chk("parity", 1'b1, watchdog_parity_ok);
        p = v;
      end
      wr(`WBC_ADDR_WD, 8'h0C);
      rd(`WBC_ADDR_WD);
      chk("wd_rsv", 8'h04, q);
      // stored 0x04 has odd parity, so the flag must drop
      chk("parity", 1'b0, watchdog_parity_ok);
      $display("test watchdog done");
    end
  endtask

  task t_bus;
    integer m;
    begin
      wr(`WBC_ADDR_BUS1, 8'hFF);
      rd(`WBC_ADDR_BUS1);
      chk("bus1_rsv", 8'hFB, q);
      chk("lin_opt", 3'h7, {lin_flash, lin_low_slope, lin_transmit_timeout_en});
      for (m = 0; m < 4; m = m + 1)
      begin
        wr(`WBC_ADDR_BUS1, {3'h0, m[1:0], 1'b0, ~m[1:0]});
        chk("modes", {m[1:0], ~m[1:0]}, {first_lin_mode, can_mode});
        wr(`WBC_ADDR_BUS2, {6'h00, m[1:0]});
        chk("second_lin_mode", m[1:0], second_lin_mode);
      end
      chk("lin_opt", 3'h0, {lin_flash, lin_low_slope, lin_transmit_timeout_en});
      wr(`WBC_ADDR_BUS2, 8'hFF);
      rd(`WBC_ADDR_BUS2);
      chk("bus2_rsv", 8'h23, q);
      @(posedge clk);
      sbc_mode <= `WBC_MODE_STOP;
      wr(`WBC_ADDR_BUS2, 8'h00);
      chk("peak", 3'h4, {peak_current_threshold, second_lin_mode});
      @(posedge clk);
      sbc_mode <= `WBC_MODE_INIT;
      wr(`WBC_ADDR_BUS2, 8'h00);
      chk("peak", 1'b0, peak_current_threshold);
      $display("test bus control done");
    end
  endtask

  task t_events;
    begin
      wr(`WBC_ADDR_WD, 8'hF6);
      wr(`WBC_ADDR_BUS1, 8'hE3);
      wr(`WBC_ADDR_BUS2, 8'h21);
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      rd(`WBC_ADDR_WD);
      chk("wd_rst", 8'hB4, q);
      rd(`WBC_ADDR_BUS1);
      chk("bus1_rst", 8'hEA, q);
      rd(`WBC_ADDR_BUS2);
      chk("bus2_rst", 8'h23, q);
      @(posedge clk);
      failsafe_entry <= 1'b1;
      @(posedge clk);
      failsafe_entry <= 1'b0;
      #1 chk("ext_wake", 17'h14707, {external_wake_force, external_wake_mask, external_wake_value});
      rd(`WBC_ADDR_BUS1);
      chk("bus1_fs", 8'hE9, q);
      rd(`WBC_ADDR_BUS2);
      chk("bus2_fs", 8'h01, q);
      @(posedge clk);
      {hw_period_we, hw_can_we, hw_stop_off_we, hw_bus_wake_we} <= 4'hF;
      {hw_first_lin_we, hw_second_lin_we, hw_stop_off_val} <= 3'h7;
      {hw_first_lin_val, hw_second_lin_val} <= 4'hA;
      @(posedge clk);
      {hw_period_we, hw_can_we, hw_stop_off_we, hw_bus_wake_we} <= 4'h0;
      {hw_first_lin_we, hw_second_lin_we} <= 2'h0;
      rd(`WBC_ADDR_WD);
      chk("wd_hw", 8'hE3, q);
      chk("period", 3'h3, watchdog_period);
      rd(`WBC_ADDR_BUS1);
      chk("bus1_hw", 8'hF3, q);
      rd(`WBC_ADDR_BUS2);
      chk("bus2_hw", 8'h02, q);
      // reserved code driven here from hardware; the host never writes it in this bench
      @(posedge clk);
      hw_period_we <= 1'b1;
      hw_period_val <= 3'h7;
      @(posedge clk);
      hw_period_we <= 1'b0;
      repeat (2) @(posedge clk);
      chk("per_rsv", 12'hBE8, {watchdog_period_reserved, watchdog_period_ms});
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      $display("test restart fail-safe hardware done");
      t_por;
    end
  endtask

  initial
  begin
    {rst_n, soft_reset, restart, failsafe_entry, hw_stop_off_we, hw_stop_off_val} = 6'h00;
    {hw_bus_wake_we, hw_bus_wake_val, hw_period_we, hw_can_we} = 4'h0;
    {hw_first_lin_we, hw_second_lin_we, hw_first_lin_val, hw_second_lin_val} = 6'h00;
    sbc_mode = `WBC_MODE_NORMAL;
    restart_can_mode = 2'h2;
    restart_first_lin_mode = 2'h1;
    restart_second_lin_mode = 2'h3;
    hw_period_val = 3'h3;
    hw_can_val = 2'h3;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_por;
    t_wd;
    t_bus;
    t_events;
    final_report;
  end
endmodule
